// >>> logic/spm_regs.svh
// timing counts, command codes and field positions for the init controller
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
`define SPM_CLK_NS          20
`define SPM_CK_DIV          2
`define SPM_T_RST_HOLD_NS   200000
`define SPM_RST_HOLD_CYC    ((`SPM_T_RST_HOLD_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_T_CKE_WAIT_NS   500000
`define SPM_CKE_WAIT_CYC    (((`SPM_T_CKE_WAIT_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS) - `SPM_CK_DIV)
`define SPM_T_XPR_NS        170
`define SPM_XPR_CYC         ((`SPM_T_XPR_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_MRD_CK          4
`define SPM_MRD_CYC         (`SPM_MRD_CK * `SPM_CK_DIV)
`define SPM_MOD_CK          12
`define SPM_MOD_CYC         (`SPM_MOD_CK * `SPM_CK_DIV)
`define SPM_T_XPDLL_NS      24
`define SPM_XPDLL_CYC       ((`SPM_T_XPDLL_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_DLLK_CK         512
`define SPM_DLLK_CYC        (`SPM_DLLK_CK * `SPM_CK_DIV)
`define SPM_ZQINIT_CK       512
`define SPM_ZQINIT_CYC      (`SPM_ZQINIT_CK * `SPM_CK_DIV)
`define SPM_T_RP_NS         14
`define SPM_RP_CYC          ((`SPM_T_RP_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_CMD_NOP         4'h7
`define SPM_CMD_MRS         4'h0
`define SPM_CMD_PREA        4'h2
`define SPM_CMD_LONG_IMPEDANCE_CALIBRATION        4'h6
`define SPM_AP_BIT          10
`define SPM_MR0_DLL_RST_BIT 8
`define SPM_MR1_DLL_DIS_BIT 0
`define SPM_BA_MR0          3'h0
`define SPM_BA_MR1          3'h1
`define SPM_BA_MR2          3'h2
`define SPM_BA_MR3          3'h3
`endif

// >>> logic/spm_pkg.sv
// types shared by the init controller and its timer
package spm_pkg;
  typedef enum {ST_PWR, ST_RST_HOLD, ST_CKE_WAIT, ST_XPR, ST_MRS, ST_MRD, ST_MOD,
                ST_LONG_IMPEDANCE_CALIBRATION, ST_CAL, ST_READY, ST_PREA, ST_VSW} spm_state_t;
  typedef logic [2:0]  spm_bank_t;
  typedef logic [15:0] spm_addr_t;
  typedef logic [23:0] spm_cnt_t;
  typedef logic [3:0]  spm_cmd_t;
endpackage

// >>> logic/spm_timer.sv
// down counter: done once the loaded number of clocks has passed
`timescale 1ns/100ps
module spm_timer (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          load,
  input  wire spm_pkg::spm_cnt_t value,
  output logic               done
);
  import spm_pkg::*;
  spm_cnt_t count;

  // saturates at zero so done stays up until the next load
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= 24'h00_0000;
    end else if (load) begin
      count <= value;
    end else if (count != 24'h00_0000) begin
      count <= count - 24'h00_0001;
    end
  end

  assign done = (count == 24'h00_0000);
endmodule

// >>> logic/spm_init_ctrl.sv
// power-up, voltage switch and mode load sequencer driving the dram pins
// Behaviour
// - hold chip reset 200us after stable power
// - clock enable low before reset release
// - wait 500us less one clock, enable low
// - raise enable on clock; only no-ops follow
// - clock runs five cycles before enable
// - termination low before enable registered high
// - enable stays high through initialization
// - first mode load targets register two
// - then registers three, one, zero with dll reset
// - allow 512 clocks for dll lock
// - long calibration; ready after both waits
// - precharge, only no-ops while supply changes
// - reload dll and calibrate after voltage change
// - only no-ops between mode loads and calibration
// - every mode load carries full register value
// - mode load only with banks idle
// - mode-to-mode interval between mode loads
// - only no-ops until mode update interval
// - enable high through mode-to-powerdown interval
// - latency change waits the longer of mode update and dll-off exit
// - termination low until mode update interval
`timescale 1ns/100ps
`include "spm_regs.svh"
module spm_init_ctrl #(
  parameter int RST_HOLD_CYC = `SPM_RST_HOLD_CYC,
  parameter int CKE_WAIT_CYC = `SPM_CKE_WAIT_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               power_stable,
  input  wire logic               vsw_req,
  input  wire logic               vsw_stable,
  input  wire spm_pkg::spm_addr_t mode_register_zero,
  input  wire spm_pkg::spm_addr_t mode_register_one,
  input  wire spm_pkg::spm_addr_t mode_register_two,
  input  wire spm_pkg::spm_addr_t mode_register_three,
  output logic                    ddr_ck,
  output logic                    ddr_reset_n,
  output logic                    ddr_cke,
  output logic                    termination_control,
  output logic                    ddr_cs_n,
  output logic                    ddr_ras_n,
  output logic                    ddr_cas_n,
  output logic                    ddr_we_n,
  output spm_pkg::spm_bank_t      ddr_ba,
  output spm_pkg::spm_addr_t      ddr_addr,
  output logic                    init_done,
  output logic                    vsw_grant
);
  import spm_pkg::*;

  localparam int MOD_XP_CYC = (`SPM_MOD_CYC > `SPM_XPDLL_CYC) ? `SPM_MOD_CYC
                                                               : `SPM_XPDLL_CYC;

  spm_state_t state;
  logic [1:0] async_in;
  logic [1:0] meta;
  logic [1:0] sync;
  logic       ps_sync;
  logic       vs_sync;
  logic       tmr_load;
  spm_cnt_t   tmr_val;
  logic       tmr_done;
  logic       dll_load;
  logic       dll_done;
  logic [1:0] mr_idx;
  spm_bank_t  mr_ba;
  spm_addr_t  mr_val;
  logic [3:0] cl_last;
  logic       cl_valid;
  logic [3:0] cl_new;
  logic       vsw_pend;
  spm_cmd_t   cmd;

  // both pins come from outside the clock domain
  assign async_in = {vsw_stable, power_stable};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          meta[gi] <= 1'b0;
          sync[gi] <= 1'b0;
        end else begin
          meta[gi] <= async_in[gi];
          sync[gi] <= meta[gi];
        end
      end
    end
  endgenerate
  assign ps_sync = sync[0];
  assign vs_sync = sync[1];

  // dram clock is clk halved and free running from reset on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ddr_ck <= 1'b0;
    end else begin
      ddr_ck <= ~ddr_ck;
    end
  end

  // shared interval timer and a separate dll lock timer
  spm_timer u_tmr (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (tmr_load),
    .value   (tmr_val),
    .done    (tmr_done)
  );
  spm_timer u_dll (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (dll_load),
    .value   (spm_cnt_t'(`SPM_DLLK_CYC)),
    .done    (dll_done)
  );

  // load order is two, three, one, zero with forced dll bits
  always_comb begin
    mr_ba  = `SPM_BA_MR2;
    mr_val = mode_register_two;
    case (mr_idx)
      2'd0: begin
        mr_ba  = `SPM_BA_MR2;
        mr_val = mode_register_two;
      end
      2'd1: begin
        mr_ba  = `SPM_BA_MR3;
        mr_val = mode_register_three;
      end
      2'd2: begin
        mr_ba  = `SPM_BA_MR1;
        mr_val = mode_register_one;
        mr_val[`SPM_MR1_DLL_DIS_BIT] = 1'b0; // dll enabled
      end
      default: begin
        mr_ba  = `SPM_BA_MR0;
        mr_val = mode_register_zero;
        mr_val[`SPM_MR0_DLL_RST_BIT] = 1'b1; // dll reset request
      end
    endcase
  end
  assign cl_new = {mode_register_zero[6:4], mode_register_zero[2]};
  assign cmd    = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};

  // sequencer: acts while ck is high so pins change at its fall
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state               <= ST_PWR;
      ddr_reset_n         <= 1'b0;
      ddr_cke             <= 1'b0;
      termination_control <= 1'b0;
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= `SPM_CMD_NOP;
      ddr_ba              <= 3'h0;
      ddr_addr            <= 16'h0000;
      tmr_load            <= 1'b0;
      tmr_val             <= 24'h00_0000;
      dll_load            <= 1'b0;
      mr_idx              <= 2'd0;
      cl_last             <= 4'h0;
      cl_valid            <= 1'b0;
      init_done           <= 1'b0;
      vsw_grant           <= 1'b0;
      vsw_pend            <= 1'b0;
    end else begin
      tmr_load <= 1'b0;
      dll_load <= 1'b0;
      if (ddr_ck) begin
        {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= `SPM_CMD_NOP;
        case (state)
          ST_PWR: begin
            if (ps_sync) begin
              tmr_load <= 1'b1;
              tmr_val  <= spm_cnt_t'(RST_HOLD_CYC);
              state    <= ST_RST_HOLD;
            end
          end
          ST_RST_HOLD: begin
            if (tmr_done) begin
              ddr_reset_n <= 1'b1;
              tmr_load    <= 1'b1;
              tmr_val     <= spm_cnt_t'(CKE_WAIT_CYC);
              state       <= ST_CKE_WAIT;
            end
          end
          ST_CKE_WAIT: begin
            if (tmr_done) begin
              ddr_cke  <= 1'b1; // never lowered again
              tmr_load <= 1'b1;
              tmr_val  <= spm_cnt_t'(`SPM_XPR_CYC);
              mr_idx   <= 2'd0;
              state    <= ST_XPR;
            end
          end
          ST_XPR: begin
            if (tmr_done) begin
              state <= ST_MRS;
            end
          end
          ST_MRS: begin
            // banks are idle here: after reset or after precharge all
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= `SPM_CMD_MRS;
            ddr_ba   <= mr_ba;
            ddr_addr <= mr_val;
            tmr_load <= 1'b1;
            mr_idx   <= mr_idx + 2'd1;
            if (mr_idx == 2'd3) begin
              dll_load <= 1'b1;
              cl_last  <= cl_new;
              cl_valid <= 1'b1;
              if (cl_valid && cl_last != cl_new) begin
                tmr_val <= spm_cnt_t'(MOD_XP_CYC);
              end else begin
                tmr_val <= spm_cnt_t'(`SPM_MOD_CYC);
              end
              state <= ST_MOD;
            end else begin
              tmr_val <= spm_cnt_t'(`SPM_MRD_CYC);
              state   <= ST_MRD;
            end
          end
          ST_MRD: begin
            if (tmr_done) begin
              state <= ST_MRS;
            end
          end
          ST_MOD: begin
            if (tmr_done) begin
              state <= ST_LONG_IMPEDANCE_CALIBRATION;
            end
          end
          ST_LONG_IMPEDANCE_CALIBRATION: begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= `SPM_CMD_LONG_IMPEDANCE_CALIBRATION;
            ddr_addr <= 16'h0400;
            tmr_load <= 1'b1;
            tmr_val  <= spm_cnt_t'(`SPM_ZQINIT_CYC);
            state    <= ST_CAL;
          end
          ST_CAL: begin
            if (tmr_done && dll_done) begin
              init_done <= 1'b1;
              state     <= ST_READY;
            end
          end
          ST_READY: begin
            if (vsw_pend) begin
              vsw_pend  <= 1'b0;
              init_done <= 1'b0;
              {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= `SPM_CMD_PREA;
              ddr_addr  <= 16'h0400;
              tmr_load  <= 1'b1;
              tmr_val   <= spm_cnt_t'(`SPM_RP_CYC);
              state     <= ST_PREA;
            end
          end
          ST_PREA: begin
            if (tmr_done) begin
              vsw_grant <= 1'b1;
              state     <= ST_VSW;
            end
          end
          ST_VSW: begin
            // only no-ops until the supply reports stable again
            if (vs_sync) begin
              vsw_grant <= 1'b0;
              mr_idx    <= 2'd0;
              state     <= ST_MRS;
            end
          end
          default: begin
            state <= ST_PWR;
          end
        endcase
      end
      // a request in the cycle it is taken still counts
      if (vsw_req) begin
        vsw_pend <= 1'b1;
      end
    end
  end

  // checking aids: counters of elapsed clocks
  logic     is_mrs;
  logic     is_nop;
  spm_cnt_t rst_low_cnt;
  spm_cnt_t rst_high_cnt;
  spm_cnt_t since_mrs;
  assign is_mrs = (cmd == `SPM_CMD_MRS);
  assign is_nop = (cmd == `SPM_CMD_NOP);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_low_cnt  <= 24'h00_0000;
      rst_high_cnt <= 24'h00_0000;
      since_mrs    <= 24'hFF_FFFF;
    end else begin
      if (ps_sync && !ddr_reset_n && rst_low_cnt != 24'hFF_FFFF) begin
        rst_low_cnt <= rst_low_cnt + 24'h00_0001;
      end
      if (ddr_reset_n && !ddr_cke && rst_high_cnt != 24'hFF_FFFF) begin
        rst_high_cnt <= rst_high_cnt + 24'h00_0001;
      end
      if (is_mrs) begin
        since_mrs <= 24'h00_0000;
      end else if (since_mrs != 24'hFF_FFFF) begin
        since_mrs <= since_mrs + 24'h00_0001;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence mrs_start;
    $rose(is_mrs);
  endsequence
  sequence quiet_gap;
    ##2 (!is_mrs) [*6];
  endsequence

  rst_hold_a: assert property ($rose(ddr_reset_n) |-> rst_low_cnt >= RST_HOLD_CYC)
    else $error("chip reset released too early");
  cke_before_rst_a: assert property ($rose(ddr_reset_n) |-> !ddr_cke && $past(!ddr_cke))
    else $error("clock enable not low at reset release");
  cke_wait_a: assert property ($rose(ddr_cke) |-> rst_high_cnt >= CKE_WAIT_CYC)
    else $error("clock enable raised before wait ended");
  xpr_nop_a: assert property (state == ST_XPR |-> is_nop)
    else $error("command other than no-op before mode loads");
  odt_setup_a: assert property ($rose(ddr_cke) |-> !termination_control && $past(!termination_control))
    else $error("termination not low before clock enable");
  cke_hold_a: assert property (ddr_cke && ddr_reset_n |=> ddr_cke)
    else $error("clock enable dropped during initialization");
  first_mr_a: assert property (mrs_start and mr_idx == 2'd1 |-> ddr_ba == 3'h2)
    else $error("first mode load not to register two");
  mr_order_a: assert property (mrs_start and state == ST_MOD |-> ddr_ba == 3'h0 && ddr_addr[8])
    else $error("last mode load not register zero with dll reset");
  ready_wait_a: assert property ($rose(init_done) |-> dll_done && tmr_done)
    else $error("ready before dll lock and calibration");
  vsw_quiet_a: assert property (vsw_grant |-> is_nop && !init_done)
    else $error("command issued during supply change");
  mrd_gap_a: assert property (mrs_start |-> quiet_gap)
    else $error("mode loads closer than mode-to-mode interval");
  mod_quiet_a: assert property (!is_nop && !is_mrs |-> since_mrs >= `SPM_MOD_CYC - 1)
    else $error("command before mode update interval");
  odt_mod_a: assert property (since_mrs < `SPM_MOD_CYC |-> !termination_control)
    else $error("termination high inside mode update interval");
endmodule

// >>> dv/spm_dram_model.sv
// behavioural dram: mode registers, termination path and command-order watch
`timescale 1ns/100ps
`include "spm_regs.svh"
module spm_dram_model (
  input  wire logic               ck,
  input  wire logic               reset_n,
  input  wire logic               cke,
  input  wire logic               termination_control,
  input  wire logic               cs_n,
  input  wire logic               ras_n,
  input  wire logic               cas_n,
  input  wire logic               we_n,
  input  wire spm_pkg::spm_bank_t ba,
  input  wire spm_pkg::spm_addr_t addr,
  output spm_pkg::spm_addr_t      mr [4],
  output logic                    term_on,
  output logic [11:0]             ba_log,
  output int                      mrs_cnt,
  output int                      zq_cnt,
  output int                      prea_cnt,
  output int                      dll_cnt,
  output int                      min_mrd,
  output int                      min_mod,
  output int                      viol
);
  import spm_pkg::*;
  spm_cmd_t cmd;
  int       gap;
  int       v;
  // deselect reads as a no-op
  assign cmd = cs_n ? `SPM_CMD_NOP : {1'b0, ras_n, cas_n, we_n};
  // counters start clean; chip reset does not clear them
  initial begin
    {mrs_cnt, zq_cnt, prea_cnt, dll_cnt, viol} = '0;
    {min_mrd, min_mod, gap} = {32'd1000, 32'd1000, 32'd1000};
    ba_log = '0;
  end
  // chip reset wipes mode values at once, not waiting for a clock that may stand
  always @(posedge ck or negedge reset_n) begin
    v = 0;
    if (!reset_n) begin
      mr <= '{default: '0};
      term_on <= 1'b0;
    end else begin
      if (cke) term_on <= 1'b1;
      if ((term_on && !cke) || (cke && termination_control)) v = 1;
      gap <= gap + 1;
      if (!cke) begin
        if (cmd != `SPM_CMD_NOP) v = 1;
      end else case (cmd)
        `SPM_CMD_NOP: ;
        `SPM_CMD_MRS: begin
          if (mrs_cnt > 0 && gap < min_mrd) min_mrd <= gap;
          mr[ba[1:0]] <= (ba == 3'h0) ? (addr & 16'hfeff) : addr;
          if (ba == 3'h0 && addr[`SPM_MR0_DLL_RST_BIT]) dll_cnt <= dll_cnt + 1;
          ba_log <= {ba_log[8:0], ba};
          mrs_cnt <= mrs_cnt + 1;
          gap <= 0;
        end
        `SPM_CMD_LONG_IMPEDANCE_CALIBRATION, `SPM_CMD_PREA: begin
          if (gap < min_mod) min_mod <= gap;
          if (!addr[`SPM_AP_BIT]) v = 1; // long form, all banks
          if (cmd == `SPM_CMD_LONG_IMPEDANCE_CALIBRATION) zq_cnt <= zq_cnt + 1;
          else prea_cnt <= prea_cnt + 1;
        end
        default: v = 1;
      endcase
      viol <= viol + v;
    end
  end
endmodule

// >>> dv/testbench.sv
// self-checking bench: power-up, voltage switch, reset with a pending switch
`timescale 1ns/100ps
`include "spm_regs.svh"
module testbench;
  import spm_pkg::*;
  localparam int RST_HOLD = 20;
  localparam int CKE_WAIT = 30;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        power_stable = 1'b0;
  logic        vsw_req = 1'b0;
  logic        vsw_stable = 1'b0;
  spm_addr_t   mrv [4] = '{16'h1520, 16'h0045, 16'h0018, 16'h0004};
  logic        ddr_ck, ddr_reset_n, ddr_cke, term, cs_n, ras_n, cas_n, we_n;
  spm_bank_t   ba;
  spm_addr_t   addr;
  logic        init_done, vsw_grant, term_on;
  spm_addr_t   mr [4];
  logic [11:0] ba_log;
  int          mrs_cnt, zq_cnt, prea_cnt, dll_cnt, min_mrd, min_mod, viol;
  int          bad_count = 0;
  int          cmp_count = 0;
  spm_init_ctrl #(.RST_HOLD_CYC(RST_HOLD), .CKE_WAIT_CYC(CKE_WAIT)) i_dut (
    .clk(clk), .reset_n(reset_n), .power_stable(power_stable), .vsw_req(vsw_req),
    .vsw_stable(vsw_stable), .mode_register_zero(mrv[0]), .mode_register_one(mrv[1]),
    .mode_register_two(mrv[2]), .mode_register_three(mrv[3]), .ddr_ck(ddr_ck),
    .ddr_reset_n(ddr_reset_n), .ddr_cke(ddr_cke), .termination_control(term),
    .ddr_cs_n(cs_n), .ddr_ras_n(ras_n), .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_ba(ba),
    .ddr_addr(addr), .init_done(init_done), .vsw_grant(vsw_grant));
  spm_dram_model i_dram (
    .ck(ddr_ck), .reset_n(ddr_reset_n), .cke(ddr_cke), .termination_control(term),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .mr(mr),
    .term_on(term_on), .ba_log(ba_log), .mrs_cnt(mrs_cnt), .zq_cnt(zq_cnt),
    .prea_cnt(prea_cnt), .dll_cnt(dll_cnt), .min_mrd(min_mrd), .min_mod(min_mod),
    .viol(viol));
  // 50 MHz clock
  initial forever #10 clk = ~clk;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded waits; a hang shows up as a failed compare, not a stuck run
  task automatic wait_done(input logic want, output int n);
    n = 0;
    while (init_done !== want && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check("init_done", want, init_done);
  endtask
  task automatic wait_grant(input logic want);
    int n;
    n = 0;
    while (vsw_grant !== want && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("vsw_grant", want, vsw_grant);
  endtask
  // what a complete load sequence must leave behind; k counts sequences so far
  task automatic check_seq(input int k);
    check("mode order", 12'h4c8, ba_log);
    check("mode loads", 4 * k, mrs_cnt);
    check("mr2", mrv[2], mr[2]);
    check("mr3", mrv[3], mr[3]);
    check("mr1", mrv[1] & 16'hfffe, mr[1]);
    check("mr0", mrv[0] & 16'hfeff, mr[0]);
    check("dll resets", k, dll_cnt);
    check("calibrations", k, zq_cnt);
    check("mrd gap", 1'b1, min_mrd >= `SPM_MRD_CK - 1);
    check("mod gap", 1'b1, min_mod >= `SPM_MOD_CK - 1);
    check("bad commands", 0, viol);
    check("cke held", 1'b1, ddr_cke);
  endtask
  task automatic t_powerup();
    int n;
    power_stable = 1'b1;
    n = 0;
    while (ddr_reset_n !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("reset hold", 1'b1, n >= RST_HOLD);
    check("cke at release", 1'b0, ddr_cke);
    check("term path", 1'b0, term_on);
    n = 0;
    while (ddr_cke !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("cke wait", 1'b1, n >= CKE_WAIT);
    n = 0;
    while (zq_cnt == 0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    wait_done(1'b1, n);
    check("cal wait", 1'b1, n >= `SPM_ZQINIT_CYC - 2 && n <= `SPM_ZQINIT_CYC + 8);
    check_seq(1);
  endtask
  task automatic t_vsw();
    int n;
    int p0;
    mrv[0] = 16'h1560; // latency bits change
    mrv[1] = 16'h0007;
    p0 = prea_cnt;
    vsw_req = 1'b1;
    @(negedge clk);
    vsw_req = 1'b0;
    wait_grant(1'b1);
    check("ready dropped", 1'b0, init_done);
    check("precharge all", p0 + 1, prea_cnt);
    repeat (60) @(negedge clk);
    check("loads held off", 4, mrs_cnt);
    check("grant kept", 1'b1, vsw_grant);
    vsw_stable = 1'b1;
    wait_done(1'b1, n);
    vsw_stable = 1'b0;
    check("grant released", 1'b0, vsw_grant);
    check_seq(2);
  endtask
  task automatic t_reset_pending();
    int n;
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    check("chip reset", 1'b0, ddr_reset_n);
    check("cke in reset", 1'b0, ddr_cke);
    check("mode wiped", 16'h0000, mr[2]);
    reset_n = 1'b1;
    @(negedge clk);
    vsw_req = 1'b1;
    @(negedge clk);
    vsw_req = 1'b0;
    wait_done(1'b1, n);
    check_seq(3);
    wait_done(1'b0, n);
    check("pending switch", 1'b1, n < 10);
    wait_grant(1'b1);
    vsw_stable = 1'b1;
    wait_done(1'b1, n);
    vsw_stable = 1'b0;
    check_seq(4);
  endtask
  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_powerup();
    t_vsw();
    t_reset_pending();
    close_out();
  end
  // four full sequences need well under this
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
